/* File: dv/bwcp_asserts.sv */
// Purpose: interface checks of the byte-wide configuration port
// Assumes: all link pins sampled on the system clock
// Notes: watches the loader-to-device link only
`timescale 1ns/1ps
module bwcp_asserts #(
    parameter int BUSY_CYC = 2 // Busy cycles per byte, four times that when encrypted
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic dev_d_oe,
    input wire logic ldr_d_oe,
    input wire logic select_n,
    input wire logic transfer_direction,
    input wire logic busy,
    input wire logic busy_oe,
    input wire logic clk_oe,
    input wire logic configuration_clock,
    input wire logic init_done
);
    localparam int BUSY_MAX = 4 * BUSY_CYC + 2; // Longest busy, encrypted
    typedef struct packed {logic clk; logic [4:0] still;} bwcp_chk_s;
    bwcp_chk_s st_ff; // Last clock level, stall count
    bwcp_chk_s nxt_st;
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    ////////////////////////////////////////////////////////////////////////
    // Count cycles the master clock stands still while in use
    always_comb begin
        nxt_st.clk = configuration_clock;
        nxt_st.still = 5'h00;
        if (clk_oe && init_done && !select_n && configuration_clock == st_ff.clk) begin
            nxt_st.still = (st_ff.still == 5'h1f) ? st_ff.still : st_ff.still + 5'h01;
        end
    end
    // Register the helper state
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_unsel;
        select_n [*4];
    endsequence
    sequence s_write_edge;
        $rose(configuration_clock) && !select_n && !transfer_direction && init_done && !busy;
    endsequence
    a_unsel_no_drive: assert property (s_unsel |-> !dev_d_oe)
        else $error("bus driven while unselected");
    a_unsel_busy_off: assert property (s_unsel |-> !busy_oe)
        else $error("busy driven while unselected");
    a_write_no_read: assert property (!transfer_direction [*4] |-> !dev_d_oe)
        else $error("bus driven in write direction");
    a_bus_one_owner: assert property (!(dev_d_oe && ldr_d_oe))
        else $error("two bus drivers");
    a_edge_takes_byte: assert property (s_write_edge |-> ##[1:6] busy)
        else $error("qualified edge took no byte");
    a_busy_ends: assert property ($rose(busy) |-> ##[1:BUSY_MAX] !busy)
        else $error("busy held too long");
    a_no_init_idle: assert property (!init_done [*4] |-> !busy)
        else $error("busy before init done");
    a_master_clock: assert property (st_ff.still < 5'h10)
        else $error("master clock stalled");
endmodule

/* File: dv/byte_wide_config_port_tb.sv */
// Purpose: self-checking bench of the byte-wide configuration port
// Assumes: loader meets device on one link, bench drives a second device
// Notes: second link covers init, readback, abort and program reset
`timescale 1ns/1ps
module byte_wide_config_port_tb;
    logic CLK_SYS_I = 1'b0; // System clock
    logic RST_N_I = 1'b0; // Reset, active low
    logic master = 1'b0, encrypted = 1'b0, slow = 1'b0, init1 = 1'b0; // Main link modes
    logic valid = 1'b0, master2 = 1'b0, init2 = 1'b0; // Offer, second device
    logic [7:0] byte_in = 8'h00, rb2 = 8'h00; // Byte sent, readback byte
    logic [7:0] cfg1, cfg2; // Accepted bytes
    logic v1, v2, ready, abort2, rbt2; // Pulses and abort state
    int miscompares = 0, samples_checked = 0, n2 = 0, nrb = 0; // Counters
    logic [7:0] exp1[$], got1[$]; // Expected and received bytes
    bwcp_if lnk();
    bwcp_if lnk2();
    bwcp_device i_bwcp_device (.CLK_SYS_I, .RST_N_I, .MASTER_I(master), .INIT_DONE_I(init1),
        .ENCRYPTED_I(encrypted), .RB_BYTE_I(8'h00), .CFG_BYTE_O(cfg1), .CFG_VALID_O(v1),
        .RB_TAKEN_O(), .ABORT_O(), .link(lnk));
    bwcp_loader i_bwcp_loader (.CLK_SYS_I, .RST_N_I, .INIT_DONE_I(init1), .RECONF_N_I(1'b1),
        .SLOW_I(slow), .BYTE_I(byte_in), .BYTE_VALID_I(valid), .BYTE_READY_O(ready),
        .link(lnk));
    bwcp_device i_bwcp_device_b (.CLK_SYS_I, .RST_N_I, .MASTER_I(master2), .INIT_DONE_I(init2),
        .ENCRYPTED_I(1'b0), .RB_BYTE_I(rb2), .CFG_BYTE_O(cfg2), .CFG_VALID_O(v2),
        .RB_TAKEN_O(rbt2), .ABORT_O(abort2), .link(lnk2));
    bwcp_asserts #(.BUSY_CYC(2)) i_bwcp_asserts (.CLK_SYS_I, .RST_N_I,
        .dev_d_oe(lnk.dev_d_oe), .ldr_d_oe(lnk.ldr_d_oe), .select_n(lnk.select_n),
        .transfer_direction(lnk.transfer_direction), .busy(lnk.busy), .busy_oe(lnk.busy_oe),
        .clk_oe(lnk.clk_oe), .configuration_clock(lnk.configuration_clock),
        .init_done(lnk.init_done));
    assign lnk2.init_done = init2;
    initial forever #4 CLK_SYS_I = ~CLK_SYS_I;
    // Bench side of the second link idles released
    initial begin
        lnk2.select_n = 1'b1;
        lnk2.transfer_direction = 1'b0;
        lnk2.ldr_d_o = 8'h00;
        lnk2.ldr_d_oe = 1'b0;
        lnk2.ldr_clk = 1'b0;
        lnk2.reconfigure_request_n = 1'b1;
    end
    // Collect accepted bytes
    always @(posedge CLK_SYS_I) begin
        if (v1 === 1'b1) got1.push_back(cfg1);
        if (v2 === 1'b1) n2++;
        if (rbt2 === 1'b1) nrb++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge CLK_SYS_I);
    endtask
    // Bytes to the loader back to back, offer held between them
    task automatic send(input logic [7:0] b[4]);
        int i;
        logic [7:0] r;
        for (int k = 0; k < 4; k++) begin
            byte_in <= b[k];
            valid <= 1'b1;
            r = {<<{b[k]}};
            i = 0;
            do begin @(posedge CLK_SYS_I); i++; end while (ready !== 1'b1 && i < 500);
            if (i >= 500) begin miscompares++; test_done(); end
            check(lnk.d, r);
            exp1.push_back(b[k]);
        end
        valid <= 1'b0;
    endtask
    // Device receipts in order, none lost or doubled
    task automatic drain;
        for (int i = 0; i < 300 && got1.size() < exp1.size(); i++) @(posedge CLK_SYS_I);
        check(8'(got1.size()), 8'(exp1.size()));
        if (got1.size() != exp1.size()) test_done();
        while (got1.size() > 0) check(got1.pop_front(), exp1.pop_front());
    endtask
    // One link clock pulse, 62.5 ns low then 62.5 ns high, then let the device settle
    task automatic tick2;
        #62.5 lnk2.ldr_clk = 1'b1;
        #62.5 lnk2.ldr_clk = 1'b0;
        cycles(8);
    endtask
    task automatic drv2(input logic sel_n, input logic dir, input logic [7:0] bus);
        @(posedge CLK_SYS_I);
        lnk2.select_n <= sel_n;
        lnk2.transfer_direction <= dir;
        lnk2.ldr_d_o <= bus;
        lnk2.ldr_d_oe <= !dir && !sel_n;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [2:0] modes[4];
        int k;
        modes = '{3'b000, 3'b010, 3'b001, 3'b110};
        cycles(4);
        RST_N_I <= 1'b1;
        cycles(10);
        init1 <= 1'b1;
        // Main link: slave, encrypted, slow clock, master encrypted
        foreach (modes[m]) begin
            {master, encrypted, slow} <= modes[m];
            cycles(20);
            send('{8'h80, 8'h01, 8'ha5, 8'h3c});
            drain();
        end
        // Second link: before init, unselected, then first byte
        drv2(1'b0, 1'b0, 8'h01);
        tick2();
        check(8'(n2), 8'h00);
        init2 <= 1'b1;
        drv2(1'b1, 1'b0, 8'h01);
        tick2();
        check(8'(n2), 8'h00);
        drv2(1'b0, 1'b0, 8'h01);
        tick2();
        check(8'(n2), 8'h01);
        check(cfg2, 8'h80);
        // Readback in slave mode, then release
        rb2 <= 8'hc1;
        drv2(1'b0, 1'b1, 8'h00);
        tick2();
        check(lnk2.d, 8'h83);
        check(8'(nrb), 8'h01);
        drv2(1'b1, 1'b0, 8'h00);
        cycles(6);
        check({6'h00, lnk2.dev_d_oe, lnk2.busy_oe}, 8'h00);
        // Master mode: direction high aborts until program reset
        master2 <= 1'b1;
        drv2(1'b0, 1'b1, 8'h00);
        cycles(20);
        check({7'h00, abort2}, 8'h01);
        k = n2;
        drv2(1'b0, 1'b0, 8'h01);
        cycles(20);
        check(8'(n2 - k), 8'h00);
        lnk2.reconfigure_request_n <= 1'b0;
        cycles(4);
        lnk2.reconfigure_request_n <= 1'b1;
        cycles(30);
        check({7'h00, abort2}, 8'h00);
        check({7'h00, n2 > k}, 8'h01);
        test_done();
    end
endmodule

/* File: src/bwcp_device.sv */
// Purpose: device end of the byte-wide configuration port
// Assumes: link pins are asynchronous and pass two flip-flops
// Notes: bytes delivered as a one-cycle pulse; readback fed by user
`timescale 1ns/1ps
module bwcp_device #(
    parameter int BUSY_CYC = 2 // Cycles busy stays high per byte, four times that when encrypted
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic MASTER_I,          // Device makes the clock
    input wire logic INIT_DONE_I,       // Initialization done
    input wire logic ENCRYPTED_I,       // Slower internal processing
    input wire logic [7:0] RB_BYTE_I,   // Readback byte
    output logic [7:0] CFG_BYTE_O,      // Accepted byte
    output logic CFG_VALID_O,           // Byte accepted pulse
    output logic RB_TAKEN_O,            // Readback byte driven pulse
    output logic ABORT_O,               // Abort status
    bwcp_if.device link
);
    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [1:0] clk_s;   // Clock sync
        logic [1:0] sel_s;   // Select sync
        logic [1:0] dir_s;   // Direction sync
        logic [1:0] prg_s;   // Program reset sync
        logic [1:0] ini_s;   // Init sync (INIT_DONE_I input)
        logic [15:0] d_s;    // Data sync, two stages
        logic clk_prev;      // Previous clock level
        logic [7:0] div;     // Master clock divider
        logic clk_out;       // Master clock level
        logic [7:0] busy_cnt; // Busy countdown
        logic [1:0] busy_h;  // Busy as shown on the pin, two cycles of history
        logic abort;         // Abort latched
        logic [7:0] byte_q;  // Accepted byte
        logic valid;         // Accept pulse
        logic rbt;           // Readback pulse
        logic [7:0] rb_q;    // Driven readback
    } bwcp_dev_s;
    bwcp_dev_s cur_ff, nxt_ff;
    logic rise;
    logic active;
    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.clk_s = {cur_ff.clk_s[0], link.configuration_clock};
        nxt_ff.sel_s = {cur_ff.sel_s[0], link.select_n};
        nxt_ff.dir_s = {cur_ff.dir_s[0], link.transfer_direction};
        nxt_ff.prg_s = {cur_ff.prg_s[0], link.reconfigure_request_n};
        nxt_ff.ini_s = {cur_ff.ini_s[0], INIT_DONE_I};
        // Pin view of busy, aged like the synced clock edge
        nxt_ff.busy_h = {cur_ff.busy_h[0], (cur_ff.busy_cnt != 8'h00) & ~cur_ff.sel_s[1]};
        nxt_ff.d_s = {cur_ff.d_s[7:0], link.d};
        nxt_ff.clk_prev = cur_ff.clk_s[1];
        nxt_ff.valid = 1'b0;
        nxt_ff.rbt = 1'b0;
        rise = cur_ff.clk_s[1] & ~cur_ff.clk_prev;
        // Port alive only after init done and before abort
        active = cur_ff.ini_s[1] & ~cur_ff.abort;
        // Master clock divider, runs only after init done
        if (MASTER_I && cur_ff.ini_s[1]) begin
            if (cur_ff.div == 8'(bwcp_pkg::MASTER_HALF_CYC - 1)) begin
                nxt_ff.div = 8'h00;
                nxt_ff.clk_out = ~cur_ff.clk_out;
            end else begin
                nxt_ff.div = cur_ff.div + 8'h01;
            end
        end else begin
            nxt_ff.div = 8'h00;
            nxt_ff.clk_out = 1'b0;
        end
        // Busy countdown per system cycle
        if (cur_ff.busy_cnt != 8'h00) begin
            nxt_ff.busy_cnt = cur_ff.busy_cnt - 8'h01;
        end
        // Edges with select high are ignored
        if (rise && active && !cur_ff.sel_s[1]) begin
            if (!cur_ff.dir_s[1]) begin
                // Busy judged as the pin showed it at the sampled edge, so the loader agrees
                if (!cur_ff.busy_h[1]) begin
                    // Line 0 is MSB
                    nxt_ff.byte_q = bwcp_pkg::bwcp_swap(cur_ff.d_s[15:8]);
                    nxt_ff.valid = 1'b1;
                    nxt_ff.busy_cnt = ENCRYPTED_I ? 8'(BUSY_CYC * 4) : 8'(BUSY_CYC);
                end
            end else if (!MASTER_I) begin
                // Readback edge in controlled mode
                nxt_ff.rb_q = bwcp_pkg::bwcp_swap(RB_BYTE_I);
                nxt_ff.rbt = 1'b1;
            end else begin
                nxt_ff.abort = 1'b1;
            end
        end
        // Program reset clears abort and restarts
        if (!cur_ff.prg_s[1]) begin
            nxt_ff.abort = 1'b0;
            nxt_ff.busy_cnt = 8'h00;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Pins and user outputs
    assign link.clk_o = cur_ff.clk_out;
    assign link.clk_oe = MASTER_I;
    assign link.busy_o = cur_ff.busy_cnt != 8'h00;
    assign link.busy_oe = ~cur_ff.sel_s[1];
    assign link.dev_d_o = cur_ff.rb_q;
    // Drive readback only when selected and reading
    assign link.dev_d_oe = ~cur_ff.sel_s[1] & cur_ff.dir_s[1] & active;
    assign CFG_BYTE_O = cur_ff.byte_q;
    assign CFG_VALID_O = cur_ff.valid;
    assign RB_TAKEN_O = cur_ff.rbt;
    assign ABORT_O = cur_ff.abort;
endmodule

/* File: src/bwcp_if.sv */
// Purpose: pins between the configuration port and its loader
// Assumes: shared 125 MHz system clock in the bench
// Notes: bus and busy wires resolved from enables here
`timescale 1ns/1ps
interface bwcp_if;
    logic [7:0] dev_d_o;     // Device data drive
    logic dev_d_oe;          // Device data enable
    logic [7:0] ldr_d_o;     // Loader data drive
    logic ldr_d_oe;          // Loader data enable
    logic [7:0] d;           // Resolved bus, line 0 is MSB
    logic select_n;          // Port select, active low
    logic transfer_direction; // Low write, high read
    logic busy_o;            // Device busy drive
    logic busy_oe;           // Busy enable
    logic busy;              // Resolved busy, floats high-less as low
    logic clk_o;             // Device-made clock
    logic clk_oe;            // Device drives clock (master)
    logic ldr_clk;           // Loader-made clock
    logic configuration_clock; // Resolved clock
    logic init_done;         // Initialization done
    logic reconfigure_request_n; // Program reset, active low
    // Wire resolution
    assign d = dev_d_oe ? dev_d_o : (ldr_d_oe ? ldr_d_o : 8'h00);
    assign busy = busy_oe ? busy_o : 1'b0;
    assign configuration_clock = clk_oe ? clk_o : ldr_clk;
    modport device (input d, select_n, transfer_direction, configuration_clock, init_done,
        reconfigure_request_n, output dev_d_o, dev_d_oe, busy_o, busy_oe, clk_o, clk_oe);
    modport loader (input d, busy, configuration_clock, clk_oe,
        output ldr_d_o, ldr_d_oe, select_n, transfer_direction, ldr_clk, init_done,
        reconfigure_request_n);
endinterface

/* File: src/bwcp_loader.sv */
// Purpose: loader end of the byte-wide configuration port
// Assumes: device pins pass two flip-flops before use
// Notes: makes the clock itself when the device is not master
`timescale 1ns/1ps
module bwcp_loader (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic INIT_DONE_I,     // Drives the init line
    input wire logic RECONF_N_I,      // Program reset request
    input wire logic SLOW_I,          // Slow clock, busy ignored
    input wire logic [7:0] BYTE_I,    // Byte to send
    input wire logic BYTE_VALID_I,    // Byte offered
    output logic BYTE_READY_O,        // Byte taken
    bwcp_if.loader link
);
    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        bwcp_pkg::bwcp_ld_e st; // Sequence state
        logic [1:0] clk_s;      // Clock sync
        logic [1:0] busy_s;     // Busy sync
        logic clk_prev;         // Previous clock
        logic [7:0] div;        // Own clock divider
        logic clk_out;          // Own clock
        logic [7:0] dat;        // Held byte
        logic sel;              // Select driven low when set
        logic [1:0] age;        // Cycles since select and data went out
    } bwcp_ld_s;
    bwcp_ld_s cur_ff, nxt_ff;
    logic rise;
    logic take;
    logic [7:0] half;
    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        nxt_ff = cur_ff;
        take = 1'b0;
        nxt_ff.clk_s = {cur_ff.clk_s[0], link.configuration_clock};
        nxt_ff.busy_s = {cur_ff.busy_s[0], link.busy};
        nxt_ff.clk_prev = cur_ff.clk_s[1];
        rise = cur_ff.clk_s[1] & ~cur_ff.clk_prev;
        // Slow mode stays under the encrypted limit
        half = SLOW_I ? 8'(bwcp_pkg::SLOW_HALF_CYC) : 8'(bwcp_pkg::MASTER_HALF_CYC);
        // Own clock, used in slave mode
        if (cur_ff.div >= half - 8'h01) begin
            nxt_ff.div = 8'h00;
            nxt_ff.clk_out = ~cur_ff.clk_out;
        end else begin
            nxt_ff.div = cur_ff.div + 8'h01;
        end
        case (cur_ff.st)
            bwcp_pkg::BWCP_IDLE: begin
                if (BYTE_VALID_I) begin
                    nxt_ff.dat = bwcp_pkg::bwcp_swap(BYTE_I);
                    nxt_ff.sel = 1'b1;
                    nxt_ff.age = 2'h0;
                    nxt_ff.st = bwcp_pkg::BWCP_EDGE;
                end else begin
                    nxt_ff.sel = 1'b0;
                end
            end
            bwcp_pkg::BWCP_EDGE: begin
                // Edges sampled before select and data reached the pins are not ours
                if (cur_ff.age != 2'h2) begin
                    nxt_ff.age = cur_ff.age + 2'h1;
                end
                // Byte counts on a rising edge without busy, or on any rising edge in slow mode
                if (rise && cur_ff.age == 2'h2) begin
                    if (SLOW_I || !cur_ff.busy_s[1]) begin
                        take = 1'b1;
                        nxt_ff.st = bwcp_pkg::BWCP_IDLE;
                    end
                    // Busy: hold the same byte for the next edge
                end
            end
            default: begin
                nxt_ff.st = bwcp_pkg::BWCP_IDLE;
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Pins
    assign BYTE_READY_O = take;
    assign link.ldr_d_o = cur_ff.dat;
    assign link.ldr_d_oe = cur_ff.sel;
    assign link.select_n = ~cur_ff.sel;
    assign link.transfer_direction = 1'b0;
    assign link.ldr_clk = cur_ff.clk_out;
    assign link.init_done = INIT_DONE_I;
    assign link.reconfigure_request_n = RECONF_N_I;
endmodule

/* File: src/bwcp_pkg.sv */
// Purpose: shared constants and types of the byte-wide configuration port
// Assumes: 125 MHz system clock on both ends
// Notes: both ends include nothing; every use is written bwcp_pkg::name
package bwcp_pkg;
    // System clock rate
    localparam int CLK_MHZ = 125;
    // Clock limit without handshake, MHz
    localparam int NO_HANDSHAKE_MHZ = 50;
    // Clock limit for encrypted streams without handshake, MHz
    localparam int ENCRYPT_NO_HANDSHAKE_MHZ = 5;
    // Master clock half period in system cycles: rounded up to stay under limit
    localparam int MASTER_HALF_CYC =
        (CLK_MHZ + 2 * NO_HANDSHAKE_MHZ - 1) / (2 * NO_HANDSHAKE_MHZ);
    // Slow half period keeping under the encrypted limit
    localparam int SLOW_HALF_CYC =
        (CLK_MHZ + 2 * ENCRYPT_NO_HANDSHAKE_MHZ - 1) / (2 * ENCRYPT_NO_HANDSHAKE_MHZ);
    // Data width of the byte port
    localparam int BYTE_W = 8;
    // Loader states
    typedef enum logic [1:0] {BWCP_IDLE, BWCP_SETUP, BWCP_EDGE, BWCP_READ} bwcp_ld_e;
    // Reverse bit order between bus lines and byte value
    function automatic logic [7:0] bwcp_swap(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction
endpackage
